// [shared/fmet_pkg.sv]
package fmet_pkg;
   localparam int REG_W = 4;
   localparam int DATA_W = 128;
   localparam int INELIG_DELAY = 2;
   localparam logic [1:0] INELIG_DELAY_C = 2'h2;
   localparam int SS_UP_LO = 32;
   localparam int SD_UP_LO = 64;
   localparam int SP_W = 32;
   localparam int DP_W = 64;
   localparam int SP_LANES = 4;
   localparam int DP_LANES = 2;
   typedef enum logic [2:0] {
      FMET_OP_OTHER,
      FMET_OP_MOVE_ELIG,
      FMET_OP_MOVE_INELIG,
      FMET_OP_COMPUTE,
      FMET_OP_CVT_SS,
      FMET_OP_CVT_SD,
      FMET_OP_ROUND
   } fmet_op_t;
   typedef enum logic [1:0] {
      FMET_RND_NEAREST,
      FMET_RND_DOWN,
      FMET_RND_UP,
      FMET_RND_TRUNC
   } fmet_rnd_t;
endpackage

// [hdl/fmet_tracker.sv]
`timescale 1ns/1ps
// Operation
// - only full-register aligned/unaligned moves eligible
// - ineligible move dest delays compute two cycles
// - hold one mapping from latest eligible move
// - elimination only for compute, moves wait
// - writes to tracked dest or source invalidate
// - newer eligible move replaces the mapping
// - redirect discards the mapping
// - dependent compute reads tracked source instead
// - unrelated writes keep the mapping valid
// - scalar convert tests upper 64/96 dest bits
// - upper bit set skips merge dependency
// - otherwise convert depends on prior dest writer
// - rounding ignores control register rounding field
// - packed round four singles or two doubles
module fmet_tracker (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic in_valid,
   input wire fmet_pkg::fmet_op_t in_op,
   input wire logic [fmet_pkg::REG_W-1:0] in_dst,
   input wire logic [fmet_pkg::REG_W-1:0] in_src,
   input wire logic in_writes_dst,
   input wire logic [fmet_pkg::DATA_W-1:0] in_dst_val,
   input wire logic in_packed,
   input wire logic in_double,
   input wire fmet_pkg::fmet_rnd_t in_imm_rnd,
   input wire logic redirect,
   output logic out_valid,
   output fmet_pkg::fmet_op_t out_op,
   output logic [fmet_pkg::REG_W-1:0] out_src,
   output logic out_bypass,
   output logic [1:0] out_delay,
   output logic out_merge_dep,
   output fmet_pkg::fmet_rnd_t out_rnd,
   output logic [2:0] out_lanes,
   output logic map_valid,
   output logic [fmet_pkg::REG_W-1:0] map_dst,
   output logic [fmet_pkg::REG_W-1:0] map_src
);
   logic map_vld_q, map_vld_d;
   logic [fmet_pkg::REG_W-1:0] map_dst_q, map_dst_d, map_src_q, map_src_d;
   logic [fmet_pkg::REG_W-1:0] inel_dst_q, inel_dst_d;
   logic inel_vld_q, inel_vld_d;
   logic o_vld_d, o_byp_d, o_mrg_d;
   fmet_pkg::fmet_op_t o_op_d;
   fmet_pkg::fmet_rnd_t o_rnd_d;
   logic [fmet_pkg::REG_W-1:0] o_src_d;
   logic [1:0] o_dly_d;
   logic [2:0] o_lanes_d;
   logic hit, upper_set;

   always_comb begin
      map_vld_d = map_vld_q;
      map_dst_d = map_dst_q;
      map_src_d = map_src_q;
      inel_vld_d = inel_vld_q;
      inel_dst_d = inel_dst_q;
      o_vld_d = 1'b0;
      o_op_d = in_op;
      o_src_d = in_src;
      o_byp_d = 1'b0;
      o_dly_d = 2'h0;
      o_mrg_d = 1'b0;
      o_rnd_d = in_imm_rnd;
      o_lanes_d = 3'h1;
      upper_set = 1'b0;
      hit = map_vld_q && (in_src == map_dst_q);
      if (redirect) begin
         map_vld_d = 1'b0;
         inel_vld_d = 1'b0;
      end else if (in_valid) begin
         o_vld_d = 1'b1;
         unique case (in_op)
            fmet_pkg::FMET_OP_COMPUTE: begin
               if (hit) begin
                  o_byp_d = 1'b1;
                  o_src_d = map_src_q;
               end else if (inel_vld_q && in_src == inel_dst_q) begin
                  o_dly_d = fmet_pkg::INELIG_DELAY_C;
               end
            end
            fmet_pkg::FMET_OP_CVT_SS, fmet_pkg::FMET_OP_CVT_SD: begin
               upper_set = (in_op == fmet_pkg::FMET_OP_CVT_SS) ?
                  |in_dst_val[fmet_pkg::DATA_W-1:fmet_pkg::SS_UP_LO] :
                  |in_dst_val[fmet_pkg::DATA_W-1:fmet_pkg::SD_UP_LO];
               o_mrg_d = !upper_set;
            end
            fmet_pkg::FMET_OP_ROUND: begin
               o_rnd_d = in_imm_rnd;
               if (in_packed) begin
                  o_lanes_d = in_double ? 3'(fmet_pkg::DP_LANES) : 3'(fmet_pkg::SP_LANES);
               end
            end
            default: begin
            end
         endcase
         if (in_writes_dst && map_vld_q &&
             (in_dst == map_dst_q || in_dst == map_src_q)) begin
            map_vld_d = 1'b0;
         end
         if (in_writes_dst && inel_vld_q && in_dst == inel_dst_q) begin
            inel_vld_d = 1'b0;
         end
         // after the overwrite check so a new move wins
         // track newest eligible move
         if (in_op == fmet_pkg::FMET_OP_MOVE_ELIG) begin
            map_vld_d = (in_dst != in_src);
            map_dst_d = in_dst;
            map_src_d = in_src;
         end
         if (in_op == fmet_pkg::FMET_OP_MOVE_INELIG) begin
            inel_vld_d = 1'b1;
            inel_dst_d = in_dst;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         map_vld_q <= 1'b0;
         map_dst_q <= '0;
         map_src_q <= '0;
         inel_vld_q <= 1'b0;
         inel_dst_q <= '0;
         out_valid <= 1'b0;
         out_op <= fmet_pkg::FMET_OP_OTHER;
         out_src <= '0;
         out_bypass <= 1'b0;
         out_delay <= 2'h0;
         out_merge_dep <= 1'b0;
         out_rnd <= fmet_pkg::FMET_RND_NEAREST;
         out_lanes <= 3'h1;
      end else begin
         map_vld_q <= map_vld_d;
         map_dst_q <= map_dst_d;
         map_src_q <= map_src_d;
         inel_vld_q <= inel_vld_d;
         inel_dst_q <= inel_dst_d;
         out_valid <= o_vld_d;
         out_op <= o_op_d;
         out_src <= o_src_d;
         out_bypass <= o_byp_d;
         out_delay <= o_dly_d;
         out_merge_dep <= o_mrg_d;
         out_rnd <= o_rnd_d;
         out_lanes <= o_lanes_d;
      end
   end

   assign map_valid = map_vld_q;
   assign map_dst = map_dst_q;
   assign map_src = map_src_q;

   map_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(rst_n) |-> !map_vld_q) else $error("mapping valid after reset");
   redirect_clr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      redirect |=> !map_valid) else $error("redirect kept mapping");
   elig_track_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (in_valid && !redirect && in_op == fmet_pkg::FMET_OP_MOVE_ELIG && in_dst != in_src)
      |=> map_valid && map_dst == $past(in_dst) && map_src == $past(in_src))
      else $error("eligible move not tracked");
   overwrite_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (in_valid && in_writes_dst && map_valid && in_op != fmet_pkg::FMET_OP_MOVE_ELIG
       && (in_dst == map_dst || in_dst == map_src)) |=> !map_valid)
      else $error("overwrite kept mapping");
   bypass_src_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (in_valid && !redirect && in_op == fmet_pkg::FMET_OP_COMPUTE && map_valid
       && in_src == map_dst) |=> out_bypass && out_src == $past(map_src))
      else $error("compute not bypassed");
   move_nobyp_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      out_bypass |-> out_op == fmet_pkg::FMET_OP_COMPUTE) else $error("move bypassed");
   inelig_dly_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      out_delay != 2'h0 |-> out_delay == fmet_pkg::INELIG_DELAY_C && !out_bypass)
      else $error("bad ineligible delay");
   merge_skip_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (in_valid && !redirect && in_op == fmet_pkg::FMET_OP_CVT_SD
       && |in_dst_val[fmet_pkg::DATA_W-1:fmet_pkg::SD_UP_LO]) |=> !out_merge_dep)
      else $error("merge not skipped");
   round_lanes_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (out_valid && out_op == fmet_pkg::FMET_OP_ROUND) |-> out_lanes inside {3'h1, 3'h2, 3'h4})
      else $error("bad lane count");
   round_packed_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (in_valid && !redirect && in_op == fmet_pkg::FMET_OP_ROUND && in_packed)
      |=> out_lanes == ($past(in_double) ? 3'(fmet_pkg::DP_LANES) : 3'(fmet_pkg::SP_LANES)))
      else $error("packed lane count wrong");
   inelig_nomap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (in_valid && in_op == fmet_pkg::FMET_OP_MOVE_INELIG && !map_valid) |=> !map_valid)
      else $error("ineligible move tracked");
   keep_map_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (in_valid && !redirect && map_valid && in_op != fmet_pkg::FMET_OP_MOVE_ELIG
       && !(in_writes_dst && (in_dst == map_dst || in_dst == map_src)))
      |=> map_valid && $stable(map_dst) && $stable(map_src))
      else $error("mapping lost without overwrite");
   merge_dep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (in_valid && !redirect && in_op == fmet_pkg::FMET_OP_CVT_SS
       && !(|in_dst_val[fmet_pkg::DATA_W-1:fmet_pkg::SS_UP_LO])) |=> out_merge_dep)
      else $error("merge dependency missing");
   merge_sd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (in_valid && !redirect && in_op == fmet_pkg::FMET_OP_CVT_SD
       && !(|in_dst_val[fmet_pkg::DATA_W-1:fmet_pkg::SD_UP_LO])) |=> out_merge_dep)
      else $error("double convert merge test wrong");
   round_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (in_valid && !redirect && in_op == fmet_pkg::FMET_OP_ROUND)
      |=> out_rnd == $past(in_imm_rnd)) else $error("rounding mode not from immediate");
   redirect_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      redirect |=> !out_valid) else $error("redirect cycle not dropped");
   inelig_hit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (in_valid && !redirect && in_op == fmet_pkg::FMET_OP_COMPUTE && inel_vld_q
       && in_src == inel_dst_q && !(map_valid && in_src == map_dst))
      |=> out_delay == fmet_pkg::INELIG_DELAY_C) else $error("ineligible delay missing");
endmodule

// [tb/fmet_dispatch.sv]
`timescale 1ns/1ps
module fmet_dispatch (
   input wire logic clk_sys,
   output logic in_valid,
   output fmet_pkg::fmet_op_t in_op,
   output logic [fmet_pkg::REG_W-1:0] in_dst,
   output logic [fmet_pkg::REG_W-1:0] in_src,
   output logic in_writes_dst,
   output logic [fmet_pkg::DATA_W-1:0] in_dst_val,
   output logic in_packed,
   output logic in_double,
   output fmet_pkg::fmet_rnd_t in_imm_rnd,
   output logic redirect
);
   initial begin
      {in_valid, in_writes_dst, in_packed, in_double, redirect} = 5'h00;
      in_op = fmet_pkg::FMET_OP_OTHER;
      {in_dst, in_src, in_dst_val} = '0;
      in_imm_rnd = fmet_pkg::FMET_RND_NEAREST;
   end
   // launched at falling edge so the rising edge sees settled fields
   task automatic issue(input fmet_pkg::fmet_op_t op, input logic [3:0] d, input logic [3:0] s,
         input logic [127:0] v, input logic [3:0] f);
      in_valid = 1'b1;
      in_op = op;
      in_dst = d;
      in_src = s;
      in_dst_val = v;
      {in_writes_dst, redirect, in_packed, in_double} = f;
      in_imm_rnd = fmet_pkg::fmet_rnd_t'(d[1:0]);
      @(negedge clk_sys);
   endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
   localparam fmet_pkg::fmet_op_t ME = fmet_pkg::FMET_OP_MOVE_ELIG;
   localparam fmet_pkg::fmet_op_t MI = fmet_pkg::FMET_OP_MOVE_INELIG;
   localparam fmet_pkg::fmet_op_t CP = fmet_pkg::FMET_OP_COMPUTE;
   localparam fmet_pkg::fmet_op_t OT = fmet_pkg::FMET_OP_OTHER;
   logic clk_sys, rst_n, in_valid, in_writes_dst, in_packed, in_double, redirect;
   logic out_valid, out_bypass, out_merge_dep, map_valid;
   fmet_pkg::fmet_op_t in_op, out_op;
   logic [fmet_pkg::REG_W-1:0] in_dst, in_src, out_src, map_dst, map_src;
   logic [fmet_pkg::DATA_W-1:0] in_dst_val;
   fmet_pkg::fmet_rnd_t in_imm_rnd, out_rnd;
   logic [1:0] out_delay;
   logic [2:0] out_lanes;
   int n_errors, checks_done, b[5], d, s;
   fmet_tracker dut_u (.clk_sys, .rst_n, .in_valid, .in_op, .in_dst, .in_src, .in_writes_dst,
      .in_dst_val, .in_packed, .in_double, .in_imm_rnd, .redirect, .out_valid, .out_op,
      .out_src, .out_bypass, .out_delay, .out_merge_dep, .out_rnd, .out_lanes, .map_valid,
      .map_dst, .map_src);
   fmet_dispatch part_u (.clk_sys, .in_valid, .in_op, .in_dst, .in_src, .in_writes_dst,
      .in_dst_val, .in_packed, .in_double, .in_imm_rnd, .redirect);
   function automatic logic [7:0] exp_dep(input logic ss, input logic [127:0] v);
      return ss ? 8'(~|v[127:32]) : 8'(~|v[127:64]);
   endfunction
   function automatic logic [7:0] exp_lanes(input logic p, input logic dbl);
      return p ? (dbl ? 8'h02 : 8'h04) : 8'h01;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      if (n_errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      rst_n = 1'b0;
      b = '{-1, 31, 32, 63, 64};
      void'($urandom(32'h6768));
      repeat (20) @(negedge clk_sys);
      chk(8'(map_valid), 8'h00);
      rst_n = 1'b1;
      part_u.issue(ME, 4'h2, 4'h1, '0, 4'h8);
      chk(8'(map_valid), 8'h01);
      part_u.issue(CP, 4'h2, 4'h2, '0, 4'h8);
      chk({4'(out_bypass), 4'(out_src)}, 8'h11);
      chk(8'(out_op), 8'(CP));
      part_u.issue(CP, 4'h3, 4'h2, '0, 4'h8);
      chk(8'(out_bypass), 8'h00);
      part_u.issue(ME, 4'h2, 4'h1, '0, 4'h8);
      part_u.issue(ME, 4'h4, 4'h3, '0, 4'h8);
      part_u.issue(CP, 4'h5, 4'h2, '0, 4'h8);
      chk(8'(out_bypass), 8'h00);
      part_u.issue(CP, 4'h6, 4'h4, '0, 4'h8);
      chk({4'(out_bypass), 4'(out_src)}, 8'h13);
      part_u.issue(ME, 4'h2, 4'h1, '0, 4'h8);
      part_u.issue(OT, 4'h1, 4'h0, '0, 4'h8);
      part_u.issue(CP, 4'h7, 4'h2, '0, 4'h8);
      chk(8'(out_bypass), 8'h00);
      part_u.issue(ME, 4'h2, 4'h1, '0, 4'h8);
      part_u.issue(MI, 4'h9, 4'h8, '0, 4'h8);
      part_u.issue(CP, 4'h7, 4'h2, '0, 4'h8);
      chk({4'(out_bypass), 4'(out_delay)}, 8'h10);
      part_u.issue(CP, 4'hA, 4'h9, '0, 4'h8);
      chk(8'(out_delay), 8'(fmet_pkg::INELIG_DELAY));
      part_u.issue(ME, 4'h2, 4'h1, '0, 4'h8);
      part_u.issue(OT, 4'h0, 4'h0, '0, 4'h4);
      chk({4'(out_valid), 4'(map_valid)}, 8'h00);
      part_u.issue(CP, 4'h7, 4'h2, '0, 4'h8);
      chk({4'(out_valid), 4'(out_bypass)}, 8'h10);
      part_u.issue(ME, 4'h2, 4'h1, '0, 4'h8);
      part_u.issue(ME, 4'h3, 4'h2, '0, 4'h8);
      chk({4'(out_bypass), 4'(map_src)}, 8'h02);
      rst_n = 1'b0;
      @(negedge clk_sys);
      chk({4'(map_valid), 4'(out_valid)}, 8'h00);
      rst_n = 1'b1;
      for (int i = 0; i < 10; i++) begin
         part_u.issue(i < 5 ? fmet_pkg::FMET_OP_CVT_SS : fmet_pkg::FMET_OP_CVT_SD, 4'h6, 4'h0,
            b[i % 5] < 0 ? '0 : 128'h1 << b[i % 5], 4'h8);
         chk(8'(out_merge_dep), exp_dep(i < 5, in_dst_val));
      end
      for (int i = 0; i < 8; i++) begin
         part_u.issue(fmet_pkg::FMET_OP_ROUND, 4'(i), 4'h0, '0, {2'b10, 2'(i >> 1)});
         chk(8'(out_rnd), 8'(i % 4));
         chk(8'(out_lanes), exp_lanes(i[2], i[1]));
      end
      for (int i = 0; i < 20; i++) begin
         d = $urandom % 16;
         s = d ^ (1 + $urandom % 15);
         part_u.issue(ME, 4'(d), 4'(s), '0, 4'h8);
         chk({4'(map_dst), 4'(map_src)}, 8'(d * 16 + s));
         part_u.issue(CP, 4'(d), 4'(d), '0, 4'h8);
         chk({4'(out_bypass), 4'(out_src)}, 8'(16 + s));
      end
      print_verdict();
   end
endmodule
